// file: src/fbsc_core.sv
/*
 Flyback switch sequencer: decides gate on/off from comparator flags.
 Assumes all flags are synchronous to clk and that the OPP estimate is a
 digitised aux-current sample taken during the primary stroke.
*/
// Contract
// - QR: switch on after demag and valley
// - Cap rate 125 kHz, then valley skipping
// - Frequency reduction: limit 25 percent, rate floats
// - Valley switching stays active in reduction
// - PFC disable in reduction, with hysteresis
// - On, off at sense limit, then secondary
// - Oscillator plus demag ended, wait valley
// - Output short lengthens off-time immediately
// - Ignore demag 2 us after turn-off
// - Aux open stops switching until cleared
// - Control above 2.5 V disconnects 3.5 V source
// - Control above 4.5 V: fault, restart
// - Control grounded: no switching
// - Soft-start source on, switch at 0.5 V
// - Soft-start source off once switching
// - On-time over 40 us: safe restart
// - OVP sampled in secondary, count up one
// - No OVP cycle: count down two, floor zero
// - Count eight: latch, stop both converters
// - Latch clears on mains 750 then 870 mV
// - Cycle current limit, blanked after switch-on
// - Input estimate lowers peak limit
// - 75 mV hysteresis leaving low-power mode
`timescale 1ns/1ps
module fbsc_core #(
   parameter int TON_MAX_CYC   = fbsc_pkg::MAX_TON_CYC,
   parameter int RESTART_CYC_P = fbsc_pkg::RESTART_CYC,
   parameter int SHORT_OFF_CYC = fbsc_pkg::MIN_PERIOD_CYC * 4
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire fbsc_pkg::fbsc_flags_t flags,
   input  wire logic [7:0]            vin_estimate,
   output fbsc_pkg::fbsc_out_t        outs
);
   import fbsc_pkg::*;

   initial begin
      if (TON_MAX_CYC < 1 || TON_MAX_CYC >= (1 << TIMER_W) ||
          RESTART_CYC_P < 1 || RESTART_CYC_P >= (1 << TIMER_W) ||
          SHORT_OFF_CYC < MIN_PERIOD_CYC) begin
         $error("fbsc_core: count parameter out of range");
      end
   end

   localparam logic [TIMER_W-1:0] TON_MAX_T  = TON_MAX_CYC[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] RESTART_T  = RESTART_CYC_P[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] SHORT_T    = SHORT_OFF_CYC[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] PERIOD_T   = MIN_PERIOD_CYC[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] SUP_T      = DEMAG_SUP_CYC[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] LEB_T      = LEB_CYC[TIMER_W-1:0];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      fbsc_state_t        st;
      logic [TIMER_W-1:0] ton;        // cycles since switch-on
      logic [TIMER_W-1:0] toff;       // cycles since switch-off
      logic [TIMER_W-1:0] period;     // cycles since last switch-on
      logic [TIMER_W-1:0] restart;    // safe-restart wait
      logic               demag_seen;
      logic               ovp_seen;
      logic [3:0]         ovp_cnt;
      logic               latched;
      logic               mains_low_seen;
      logic               fred;
      logic               ctrl_connect;
      logic               short_ext;
      logic [7:0]         opp;
   } fbsc_core_state_t;

   fbsc_core_state_t s_reg;
   fbsc_core_state_t s_next;

   logic fault_stop;
   logic osc_ready;
   logic demag_valid;
   logic vskip;
   logic [7:0] reduced_lvl;

   always_comb begin
      s_next      = s_reg;
      reduced_lvl = 8'((16'(LVL_FULL) * 16'(FREQ_RED_PCT)) / 16'h0064);
      fault_stop  = flags.aux_open || flags.ctrl_grounded || s_reg.latched;
      demag_valid = flags.demag && (s_reg.toff >= SUP_T);
      // Short stretches the enforced period, so off-time grows at once
      osc_ready   = s_reg.period >= (s_reg.short_ext ? SHORT_T : PERIOD_T);
      vskip       = !s_reg.fred && !(s_reg.period >= PERIOD_T) && s_reg.demag_seen;

      if (s_reg.ton != {TIMER_W{1'b1}}) s_next.ton = s_reg.ton + 1'b1;
      if (s_reg.toff != {TIMER_W{1'b1}}) s_next.toff = s_reg.toff + 1'b1;
      if (s_reg.period != {TIMER_W{1'b1}}) s_next.period = s_reg.period + 1'b1;

      // Control pin source disconnect and mode decision with hysteresis
      s_next.ctrl_connect = !flags.ctrl_above_2v5;
      if (!s_reg.fred && flags.ctrl_low_enter) s_next.fred = 1'b1;
      else if (s_reg.fred && flags.ctrl_low_exit) s_next.fred = 1'b0;

      // Latch release needs a full low-then-high mains sequence
      if (s_reg.latched && flags.mains_below_750) s_next.mains_low_seen = 1'b1;
      if (s_reg.latched && s_reg.mains_low_seen && flags.mains_above_870) begin
         s_next.latched        = 1'b0;
         s_next.mains_low_seen = 1'b0;
         s_next.ovp_cnt        = OVP_CNT_RESET;
      end

      unique case (s_reg.st)
         FBSC_ST_OFF: begin
            if (flags.supply_ok) s_next.st = FBSC_ST_SOFT;
         end
         FBSC_ST_SOFT: begin
            if (flags.sense_ss_done && !fault_stop && !flags.ctrl_above_4v5) begin
               s_next.st     = FBSC_ST_PRIMARY;
               s_next.ton    = '0;
               s_next.period = '0;
            end
         end
         FBSC_ST_PRIMARY: begin
            s_next.opp = vin_estimate;
            if (fault_stop) begin
               // A cut stroke still needs demag before the next one may start
               s_next.st         = FBSC_ST_SECONDARY;
               s_next.toff       = '0;
               s_next.demag_seen = 1'b0;
               s_next.ovp_seen   = 1'b0;
            end else if (s_reg.ton >= TON_MAX_T || flags.ctrl_above_4v5) begin
               s_next.st      = FBSC_ST_RESTART;
               s_next.restart = '0;
            end else if (s_reg.ton >= LEB_T &&
                         (s_reg.fred ? flags.cur_reduced : flags.cur_limit)) begin
               s_next.st         = FBSC_ST_SECONDARY;
               s_next.toff       = '0;
               s_next.demag_seen = 1'b0;
               s_next.ovp_seen   = 1'b0;
            end
         end
         FBSC_ST_SECONDARY: begin
            if (flags.ovp_trip) s_next.ovp_seen = 1'b1;
            s_next.short_ext = flags.short_detect;
            if (demag_valid) begin
               s_next.demag_seen = 1'b1;
               s_next.st         = FBSC_ST_WAIT;
               if (s_reg.ovp_seen || flags.ovp_trip) begin
                  if (s_reg.ovp_cnt < OVP_TRIP_COUNT)
                     s_next.ovp_cnt = s_reg.ovp_cnt + 1'b1;
                  if (s_reg.ovp_cnt + 1'b1 >= OVP_TRIP_COUNT)
                     s_next.latched = 1'b1;
               end else begin
                  s_next.ovp_cnt = (s_reg.ovp_cnt > 4'h2) ?
                                   s_reg.ovp_cnt - 4'h2 : 4'h0;
               end
            end
         end
         FBSC_ST_WAIT: begin
            // Valley timing is kept in every mode, including reduction
            if (!fault_stop && !flags.ctrl_above_4v5 && s_reg.demag_seen &&
                osc_ready && flags.valley) begin
               s_next.st     = FBSC_ST_PRIMARY;
               s_next.ton    = '0;
               s_next.period = '0;
            end else if (flags.ctrl_above_4v5) begin
               s_next.st      = FBSC_ST_RESTART;
               s_next.restart = '0;
            end
         end
         FBSC_ST_RESTART: begin
            if (s_reg.restart != {TIMER_W{1'b1}}) s_next.restart = s_reg.restart + 1'b1;
            if (s_reg.restart >= RESTART_T) s_next.st = FBSC_ST_SOFT;
         end
         default: s_next.st = FBSC_ST_OFF;
      endcase

      // Supply loss dominates everything and clears protection
      if (!flags.supply_ok) begin
         s_next.st             = FBSC_ST_OFF;
         s_next.ovp_cnt        = OVP_CNT_RESET;
         s_next.latched        = 1'b0;
         s_next.mains_low_seen = 1'b0;
         s_next.short_ext      = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: FBSC_ST_OFF, ton: '0, toff: '0, period: '0, restart: '0,
                    demag_seen: 1'b0, ovp_seen: 1'b0, ovp_cnt: OVP_CNT_RESET,
                    latched: 1'b0, mains_low_seen: 1'b0, fred: 1'b0,
                    ctrl_connect: 1'b1, short_ext: 1'b0, opp: LVL_FULL};
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      outs.switch_gate_output = (s_reg.st == FBSC_ST_PRIMARY);
      outs.softstart_src_en   = (s_reg.st == FBSC_ST_SOFT);
      outs.ctrl_src_connect   = s_reg.ctrl_connect;
      outs.pfc_disable        = s_reg.fred || s_reg.latched;
      outs.protect_latched    = s_reg.latched;
      outs.peak_limit_reduced = s_reg.fred;
      outs.mode               = s_reg.fred ? FBSC_MODE_FRED :
                                (vskip ? FBSC_MODE_VSKIP : FBSC_MODE_QR);
      outs.opp_limit          = s_reg.fred ? reduced_lvl :
                                8'(LVL_FULL - (s_reg.opp >> 2));
   end

endmodule : fbsc_core

// file: src/fbsc_pkg.sv
/*
 Package for the flyback switch sequencer: timing counts, thresholds, mode
 enumeration and the packed carriers for comparator flags and outputs.
 Assumes a 100 MHz block clock.
*/
package fbsc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int MAX_FREQ_KHZ     = 125;
   localparam int MIN_PERIOD_CYC   = (CLK_MHZ * 1000 + MAX_FREQ_KHZ - 1) / MAX_FREQ_KHZ;
   localparam int DEMAG_SUP_US     = 2;
   localparam int DEMAG_SUP_CYC    = DEMAG_SUP_US * CLK_MHZ;
   localparam int MAX_TON_US       = 40;
   localparam int MAX_TON_CYC      = MAX_TON_US * CLK_MHZ;
   localparam int LEB_NS           = 300;
   localparam int LEB_CYC          = (LEB_NS * CLK_MHZ + 999) / 1000;
   localparam int RESTART_US       = 1000;
   localparam int RESTART_CYC      = RESTART_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Levels and counters
   // ---------------------------------------------------------------
   localparam int         LVL_W          = 8;
   localparam logic [7:0] LVL_FULL       = 8'hFF;
   localparam int         FREQ_RED_PCT   = 25;
   localparam int         OVP_CNT_W      = 4;
   localparam logic [3:0] OVP_CNT_RESET  = 4'h0;
   localparam logic [3:0] OVP_TRIP_COUNT = 4'h8;
   localparam int         TIMER_W        = 24;

   typedef enum logic [1:0] {
      FBSC_MODE_QR,
      FBSC_MODE_VSKIP,
      FBSC_MODE_FRED
   } fbsc_mode_t;

   typedef enum logic [2:0] {
      FBSC_ST_OFF,
      FBSC_ST_SOFT,
      FBSC_ST_PRIMARY,
      FBSC_ST_SECONDARY,
      FBSC_ST_WAIT,
      FBSC_ST_RESTART
   } fbsc_state_t;

   // Comparator flags from the analog front end, already synchronous
   typedef struct packed {
      logic supply_ok;        // supply above start-up level
      logic demag;            // secondary stroke ended
      logic valley;           // drain voltage at minimum
      logic cur_limit;        // sense above control-derived limit
      logic cur_reduced;      // sense above reduced (25 %) limit
      logic sense_ss_done;    // sense pin reached 0.5 V
      logic ovp_trip;         // aux current above OVP level
      logic aux_open;         // aux winding input open
      logic ctrl_above_2v5;   // control pin above 2.5 V
      logic ctrl_above_4v5;   // control pin above 4.5 V
      logic ctrl_grounded;    // control pin held at ground
      logic ctrl_low_enter;   // control below frequency-reduction entry
      logic ctrl_low_exit;    // control above entry plus 75 mV
      logic mains_below_750;  // mains sense below 750 mV
      logic mains_above_870;  // mains sense above 870 mV
      logic short_detect;     // output short seen on demag timing
   } fbsc_flags_t;

   typedef struct packed {
      logic       switch_gate_output;
      logic       softstart_src_en;
      logic       ctrl_src_connect;
      logic       pfc_disable;
      logic       protect_latched;
      logic       peak_limit_reduced;
      fbsc_mode_t mode;
      logic [7:0] opp_limit;
   } fbsc_out_t;

endpackage : fbsc_pkg

// file: verif/fbsc_plant.sv
/* Switch, transformer and comparator model for the sequencer.
 Assumes gate high means switch on; flags are registered-clean. */
`timescale 1ns/1ps
module fbsc_plant (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        gate,
   input  wire logic        ovp_on,
   input  wire logic [15:0] t_on,
   input  wire logic [15:0] t_dem,
   output logic             demag,
   output logic             valley,
   output logic             cur_limit,
   output logic             ovp_trip
);
   logic [15:0] cnt;
   logic        gd;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 16'h0;
         gd  <= 1'b0;
      end else begin
         gd  <= gate;
         cnt <= (gate != gd) ? 16'h1 : cnt + 16'h1;
      end
   end
   // Flags derive from registers only, so they are clk-synchronous
   assign cur_limit = gate && cnt >= t_on;
   assign demag     = !gate && cnt >= t_dem;
   // Ringing gives a valley every 8 cycles once demagnetized
   assign valley    = demag && cnt[2:0] == 3'h0;
   assign ovp_trip  = !gate && !demag && ovp_on;
endmodule : fbsc_plant

// file: verif/fbsc_props.sv
/* Port checker for the flyback sequencer.
 Assumes flags come in synchronous to clk. */
`timescale 1ns/1ps
module fbsc_props
   import fbsc_pkg::*;
#(parameter int TON_MAX_CYC = MAX_TON_CYC) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire fbsc_flags_t flags,
   input wire logic [7:0]  vin_estimate,
   input wire fbsc_out_t   outs
);
   logic [15:0] on_cnt;
   logic [15:0] per_cnt;
   logic        g;
   logic        g_d;
   assign g = outs.switch_gate_output;
   // Period counter restarts at each switch-on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt  <= 16'h0;
         per_cnt <= 16'h0;
         g_d     <= 1'b0;
      end else begin
         g_d     <= g;
         on_cnt  <= g ? on_cnt + 16'h1 : 16'h0;
         per_cnt <= (g && !g_d) ? 16'h1 : (per_cnt == 16'hFFFF ? per_cnt : per_cnt + 16'h1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rise;
      !g ##1 g;
   endsequence
   start_cause_a: assert property (s_rise |-> $past(flags.valley) || $past(outs.softstart_src_en))
      else $error("gate rose without valley or soft start");
   min_period_a: assert property (s_rise ##0 !$past(outs.softstart_src_en) |-> per_cnt >= 16'(MIN_PERIOD_CYC - 1))
      else $error("switching period below cap");
   supply_off_a: assert property (!flags.supply_ok |=> !g && !outs.protect_latched)
      else $error("gate or latch with supply low");
   aux_open_a: assert property (flags.aux_open |=> !g)
      else $error("gate on with aux open");
   ctrl_gnd_a: assert property (flags.ctrl_grounded |=> !g)
      else $error("gate on with control grounded");
   ctrl_fault_a: assert property (flags.ctrl_above_4v5 |=> !g)
      else $error("gate on with control fault");
   src_disc_a: assert property (flags.ctrl_above_2v5 |=> !outs.ctrl_src_connect)
      else $error("control source still connected");
   latch_stop_a: assert property (outs.protect_latched |-> !g && outs.pfc_disable)
      else $error("converter running while latched");
   fred_outs_a: assert property (outs.peak_limit_reduced |-> outs.pfc_disable && outs.opp_limit == 8'h3F)
      else $error("reduction outputs wrong");
   ss_off_a: assert property (g |-> !outs.softstart_src_en)
      else $error("soft start source on while switching");
   ton_max_a: assert property (on_cnt <= 16'(TON_MAX_CYC + 1))
      else $error("on-time over limit");
endmodule : fbsc_props

bind fbsc_core fbsc_props #(.TON_MAX_CYC(TON_MAX_CYC)) props_u (.clk(clk), .rst_n(rst_n),
   .flags(flags), .vin_estimate(vin_estimate), .outs(outs));

// file: verif/tb.sv
/* Self-checking bench for the flyback sequencer.
 Assumes the plant model closes the loop on the gate. */
`timescale 1ns/1ps
module tb;
   import fbsc_pkg::*;
   localparam int TON = 1000;
   logic        clk, rst_n, ovp_on, dm, vl, cl, ot;
   logic [7:0]  vin;
   logic [15:0] t_on, t_dem;
   fbsc_flags_t f, fl;
   fbsc_out_t   o;
   int          errors, n_checks, n, ton, toff;
   always_comb begin
      fl = f; fl.demag = dm; fl.valley = vl; fl.cur_limit = cl; fl.cur_reduced = cl; fl.ovp_trip = ot;
   end
   fbsc_core #(.TON_MAX_CYC(TON), .RESTART_CYC_P(50)) dut_u (.clk(clk), .rst_n(rst_n),
      .flags(fl), .vin_estimate(vin), .outs(o));
   fbsc_plant plant_u (.clk(clk), .rst_n(rst_n), .gate(o.switch_gate_output), .ovp_on(ovp_on),
      .t_on(t_on), .t_dem(t_dem), .demag(dm), .valley(vl), .cur_limit(cl), .ovp_trip(ot));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------
   // Helpers: outputs are read at the edge, before it lands
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wc(input int k);
      repeat (k) @(posedge clk);
   endtask : wc
   task automatic wg(input logic lv, output int c);
      c = 0;
      while (o.switch_gate_output !== lv) begin
         @(posedge clk);
         c++;
         if (c > 20000) begin
            errors++;
            $display("unexpected gate wait: expected %b seen timeout", lv);
            wrap_up();
         end
      end
   endtask : wg
   task automatic period(output int a, output int b);
      wg(0, n); wg(1, n); wg(0, a); wg(1, b);
   endtask : period
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_start();
      f.supply_ok <= 1'b1; wc(3);
      chk("softstart", o.softstart_src_en, 1);
      wc(20); chk("early gate", o.switch_gate_output, 0);
      f.sense_ss_done <= 1'b1; wg(1, n);
      chk("softstart off", o.softstart_src_en, 0);
      $display("t_start done");
   endtask : t_start
   task automatic t_cycles();
      vin <= 8'h40; period(ton, toff);
      chk("blanking", ton >= LEB_CYC, 1);
      chk("rate cap", ton + toff >= MIN_PERIOD_CYC - 1, 1);
      chk("opp limit", o.opp_limit, 8'hEF);
      wg(0, n); wc(300); chk("vskip mode", o.mode, FBSC_MODE_VSKIP);
      t_on <= 16'd700; period(ton, toff); period(ton, toff);
      chk("demag ignore", toff >= DEMAG_SUP_CYC && toff <= DEMAG_SUP_CYC + 10, 1);
      t_on <= 16'd5; f.short_detect <= 1'b1; period(ton, toff); period(ton, toff);
      chk("short off", ton + toff >= 3199, 1);
      f.short_detect <= 1'b0; period(ton, toff);
      $display("t_cycles done");
   endtask : t_cycles
   task automatic t_fred();
      f.ctrl_low_enter <= 1'b1; wc(3);
      chk("reduced", o.peak_limit_reduced, 1);
      chk("mode", o.mode, FBSC_MODE_FRED);
      chk("pfc off", o.pfc_disable, 1);
      period(ton, toff); chk("fred limit", o.opp_limit, 8'h3F);
      f.ctrl_low_enter <= 1'b0; wc(5); chk("hysteresis", o.pfc_disable, 1);
      f.ctrl_low_exit <= 1'b1; wc(3); chk("pfc on", o.pfc_disable, 0);
      f.ctrl_low_exit <= 1'b0;
      $display("t_fred done");
   endtask : t_fred
   task automatic t_ovp();
      logic [9:0] pat;
      pat = 10'h3F7;
      wg(1, n);
      for (int i = 0; i < 10; i++) begin
         ovp_on <= pat[i]; wg(0, n); wg(1, n);
      end
      chk("latch at 7", o.protect_latched, 0);
      ovp_on <= 1'b1; wg(0, n); wc(300); ovp_on <= 1'b0;
      chk("latch at 8", o.protect_latched, 1);
      chk("gate latched", o.switch_gate_output, 0);
      f.mains_above_870 <= 1'b1; wc(3); chk("no early clear", o.protect_latched, 1);
      f.mains_above_870 <= 1'b0; f.mains_below_750 <= 1'b1; wc(3);
      f.mains_below_750 <= 1'b0; f.mains_above_870 <= 1'b1; wc(3);
      chk("latch clear", o.protect_latched, 0);
      f.mains_above_870 <= 1'b0; wg(1, n);
      $display("t_ovp done");
   endtask : t_ovp
   task automatic t_faults();
      for (int i = 0; i < 4; i++) begin
         wg(1, n);
         f.aux_open <= (i == 0); f.ctrl_grounded <= (i == 1);
         f.supply_ok <= (i != 2); f.ctrl_above_4v5 <= (i == 3); wc(3);
         chk("fault gate", o.switch_gate_output, 0);
         f.aux_open <= 1'b0; f.ctrl_grounded <= 1'b0; f.supply_ok <= 1'b1; f.ctrl_above_4v5 <= 1'b0;
         wg(1, n);
      end
      chk("src on", o.ctrl_src_connect, 1);
      f.ctrl_above_2v5 <= 1'b1; wc(3); chk("src off", o.ctrl_src_connect, 0);
      f.ctrl_above_2v5 <= 1'b0;
      t_on <= 16'hFFFF; wg(0, n); wg(1, n); wg(0, ton);
      chk("max on", ton >= TON - 1 && ton <= TON + 1, 1);
      t_on <= 16'd5; wg(1, n);
      $display("t_faults done");
   endtask : t_faults
   initial begin
      f = '0; rst_n = 1'b0; ovp_on = 1'b0; vin = 8'h00; t_on = 16'd5; t_dem = 16'd10;
      errors = 0; n_checks = 0;
      wc(3); rst_n <= 1'b1;
      t_start(); t_cycles(); t_fred(); t_ovp(); t_faults();
      wrap_up();
   end
endmodule : tb
